// ===== rtl/printer_port_map.vh
// Register offsets, field positions, reset values and timing counts of the printer port.
`ifndef PRINTER_PORT_MAP_VH
`define PRINTER_PORT_MAP_VH
`define OFS_DATA_OUT 4'h0
`define OFS_STATUS 4'h4
`define OFS_CONTROL 4'h8
`define OFS_IRQ_STATUS 4'hc
`define OFS_IRQ_MASK 4'h0
`define OFS_IRQ_MASK_B 5'h10
`define OFS_DATA_IN 5'h14
`define OFS_DATA_OUT_B 5'h00
`define OFS_STATUS_B 5'h04
`define OFS_CONTROL_B 5'h08
`define OFS_IRQ_STATUS_B 5'h0c
`define ST_BUSY 7
`define ST_ACK 6
`define ST_PAPER 5
`define ST_SELECT 4
`define ST_ERROR 3
`define CT_DIR 5
`define CT_IRQEN 4
`define CT_SELIN 3
`define CT_INIT 2
`define CT_AUTOLF 1
`define CT_STROBE 0
`define CTRL_RESET 8'h04
`define CTRL_UNUSED 8'hc0
`define STATUS_UNUSED 8'h07
`define IRQ_ACK_RISE 0
`define IRQ_STROBE_DONE 1
`define GUARD_NS 500
`define CLK_NS 10
`define GUARD_CYC ((`GUARD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== rtl/printer_port_status_control.v
// Printer port status buffer, control latch, data latch and AXI4-Lite register slave.
`timescale 1ns/1ps
`include "printer_port_map.vh"
module printer_port_status_control #(
  parameter DATA_W = 8,
  parameter GUARD_CYCLES = `GUARD_CYC
) (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire [4:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire [4:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [DATA_W-1:0] pd_in,
  output reg [DATA_W-1:0] pd_out,
  output reg pd_oe_n_out,
  input wire busy_in,
  input wire ack_n_in,
  input wire paper_out_in,
  input wire select_in,
  input wire error_n_in,
  output reg strobe_n_out,
  output reg init_n_out,
  output reg select_in_n_out,
  output reg auto_lf_n_out,
  output reg irq_out
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  reg [DATA_W-1:0] data_q;
  reg [7:0] ctrl_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg ack_prev_q;
  reg [15:0] guard_q;
  reg strobe_act_q;
  reg strobe_req_q;
  reg aw_full_q;
  reg w_full_q;
  reg [4:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;
  reg [7:0] status_w;
  reg [7:0] ctrl_rd_w;
  reg [31:0] rd_w;
  reg rd_ok_w;
  wire wr_go;
  wire ack_rise;
  wire strobe_want;
  wire guard_done;
  wire strobe_fell;

  // ------------------------------------------------------------------
  // Status view
  // ------------------------------------------------------------------
  always @* begin
    status_w = `STATUS_UNUSED;
    status_w[`ST_BUSY] = busy_in;
    status_w[`ST_ACK] = ack_n_in;
    status_w[`ST_PAPER] = paper_out_in;
    status_w[`ST_SELECT] = select_in;
    status_w[`ST_ERROR] = error_n_in;
    ctrl_rd_w = (ctrl_q & 8'h1f) | `CTRL_UNUSED;
  end

  // ------------------------------------------------------------------
  // Read decode
  // ------------------------------------------------------------------
  always @* begin
    rd_w = 32'h0000_0000;
    rd_ok_w = 1'b1;
    case (s_axi_araddr_in)
      `OFS_DATA_OUT_B: rd_w[DATA_W-1:0] = data_q;
      `OFS_STATUS_B: rd_w[7:0] = status_w;
      `OFS_CONTROL_B: rd_w[7:0] = ctrl_rd_w;
      `OFS_IRQ_STATUS_B: rd_w[1:0] = irq_stat_q;
      `OFS_IRQ_MASK_B: rd_w[1:0] = irq_mask_q;
      `OFS_DATA_IN: rd_w[DATA_W-1:0] = pd_in;
      default: rd_ok_w = 1'b0;
    endcase
  end

  assign wr_go = aw_full_q && w_full_q && !s_axi_bvalid_out;
  assign ack_rise = ack_n_in && !ack_prev_q;
  // A strobe is only let out once the data has settled for the guard time, and
  // the latch is frozen while the strobe is high and for the guard time after.
  assign strobe_want = ctrl_q[`CT_STROBE];
  assign guard_done = (guard_q == 16'h0000);
  assign strobe_fell = strobe_act_q && !strobe_want;

  // ------------------------------------------------------------------
  // Bus handshake and registers
  // ------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rresp_out <= 2'b00;
      s_axi_rdata_out <= 32'h0000_0000;
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 5'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      data_q <= {DATA_W{1'b0}};
      ctrl_q <= `CTRL_RESET;
      irq_stat_q <= 2'b00;
      irq_mask_q <= 2'b00;
      ack_prev_q <= 1'b1;
      guard_q <= 16'h0000;
      strobe_act_q <= 1'b0;
      strobe_req_q <= 1'b0;
    end else begin
      ack_prev_q <= ack_n_in;
      s_axi_awready_out <= !aw_full_q && !s_axi_awready_out && s_axi_awvalid_in;
      s_axi_wready_out <= !w_full_q && !s_axi_wready_out && s_axi_wvalid_in;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
      // Strobe pacing: count the guard before raising and after dropping.
      if (!guard_done) begin
        guard_q <= guard_q - 16'h0001;
      end
      if (strobe_want && !strobe_act_q && guard_done) begin
        strobe_act_q <= 1'b1;
      end else if (strobe_fell) begin
        strobe_act_q <= 1'b0;
        guard_q <= GUARD_CYCLES[15:0];
        strobe_req_q <= 1'b1;
      end else if (guard_done && strobe_req_q) begin
        strobe_req_q <= 1'b0;
      end
      irq_stat_q[`IRQ_ACK_RISE] <= irq_stat_q[`IRQ_ACK_RISE];
      irq_stat_q[`IRQ_STROBE_DONE] <= irq_stat_q[`IRQ_STROBE_DONE];
      if (wr_go) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= 2'b00;
        if (w_strb_q[0]) begin
          case (aw_addr_q)
            `OFS_DATA_OUT_B: begin
              // Changing data under a live strobe would break the hold window.
              if (!strobe_act_q && !strobe_req_q) begin
                data_q <= w_data_q[DATA_W-1:0];
                guard_q <= GUARD_CYCLES[15:0];
              end
            end
            `OFS_CONTROL_B: ctrl_q <= w_data_q[7:0] & 8'h3f;
            `OFS_IRQ_STATUS_B: irq_stat_q <= irq_stat_q & ~w_data_q[1:0];
            `OFS_IRQ_MASK_B: irq_mask_q <= w_data_q[1:0];
            `OFS_STATUS_B: s_axi_bresp_out <= 2'b10;
            `OFS_DATA_IN: s_axi_bresp_out <= 2'b10;
            default: s_axi_bresp_out <= 2'b10;
          endcase
        end
      end
      // Hardware sets win over a same-cycle software clear.
      if (ack_rise && ctrl_q[`CT_IRQEN]) begin
        irq_stat_q[`IRQ_ACK_RISE] <= 1'b1;
      end
      if (strobe_fell) begin
        irq_stat_q[`IRQ_STROBE_DONE] <= 1'b1;
      end
      if (s_axi_arvalid_in && !s_axi_arready_out && !s_axi_rvalid_out) begin
        s_axi_arready_out <= 1'b1;
        s_axi_rdata_out <= rd_w;
        s_axi_rresp_out <= rd_ok_w ? 2'b00 : 2'b10;
      end else begin
        s_axi_arready_out <= 1'b0;
      end
      if (s_axi_arready_out) begin
        s_axi_rvalid_out <= 1'b1;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // Printer pins
  // ------------------------------------------------------------------
  always @(posedge clk_sys_in) begin
    if (!resetn_in) begin
      pd_out <= {DATA_W{1'b0}};
      pd_oe_n_out <= 1'b0;
      strobe_n_out <= 1'b1;
      init_n_out <= 1'b0;
      select_in_n_out <= 1'b1;
      auto_lf_n_out <= 1'b1;
      irq_out <= 1'b0;
    end else begin
      pd_out <= data_q;
      pd_oe_n_out <= ctrl_q[`CT_DIR];
      strobe_n_out <= !strobe_act_q;
      init_n_out <= ctrl_q[`CT_INIT];
      select_in_n_out <= !ctrl_q[`CT_SELIN];
      auto_lf_n_out <= !ctrl_q[`CT_AUTOLF];
      irq_out <= |(irq_stat_q & irq_mask_q);
    end
  end

endmodule // printer_port_status_control

// ===== bench/printer_model.sv
// Printer model: answers each strobe with busy and an acknowledge pulse.
`timescale 1ns/1ps
module printer_model #(parameter DLY = 20, parameter ACK = 10) (
  input wire clk_in,
  input wire strobe_n_in,
  input wire [7:0] pd_in,
  output reg busy_out,
  output reg ack_n_out,
  output reg [7:0] got_out
);
  initial begin
    busy_out = 1'b0;
    ack_n_out = 1'b1;
    got_out = 8'h00;
    forever begin
      @(negedge strobe_n_in);
      busy_out = 1'b1;
      @(posedge strobe_n_in);
      got_out = pd_in;
      repeat (DLY) @(posedge clk_in);
      #1 ack_n_out = 1'b0;
      repeat (ACK) @(posedge clk_in);
      #1 ack_n_out = 1'b1;
      busy_out = 1'b0;
    end
  end
endmodule // printer_model

// ===== bench/printer_port_status_control_properties.sv
// Concurrent checks on the printer port bus answers and strobe timing.
`timescale 1ns/1ps
module pp_props (
  input wire clk_sys_in,
  input wire resetn_in,
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  input wire [7:0] pd_out,
  input wire strobe_n_out,
  input wire irq_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  reset_quiet_a: assert property (disable iff (1'b0) !resetn_in |=> strobe_n_out
    && !irq_out && !s_axi_bvalid_out && !s_axi_rvalid_out) else $error("active in reset");
  bvalid_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
    else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out
    && $stable(s_axi_rdata_out)) else $error("read answer changed");
  read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("late read answer");
  write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out |-> ##[1:4]
    s_axi_bvalid_out) else $error("late write answer");
  upper_zero_a: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  data_after_a: assert property ($rose(strobe_n_out) |-> $stable(pd_out) [*2])
    else $error("data moved after strobe");
  data_before_a: assert property ($fell(strobe_n_out) |-> pd_out == $past(pd_out, 2))
    else $error("data moved before strobe");
  cover property ($fell(strobe_n_out));
  cover property ($rose(irq_out));
  cover property (s_axi_bvalid_out && s_axi_bready_in);
endmodule // pp_props
bind printer_port_status_control pp_props i_pp_props (.*);

// ===== bench/printer_port_status_control_bench.sv
// Self-checking bench for the printer port registers, pins and printer handshake.
`timescale 1ns/1ps
module printer_port_status_control_bench;
  reg clk = 0, rstn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0, pe = 0, sl = 1, er = 1;
  reg [4:0] aw = 0, ar = 0;
  reg [31:0] wd = 0, x;
  reg [7:0] ext = 0, c, d = 0;
  reg [3:0] ws = 4'hf;
  wire awr, wrd, bv, arr, rv, oe_n, stb_n, ini_n, sel_n, alf_n, irq, busy, ackn;
  wire [1:0] bresp, rresp;
  wire [31:0] rdat;
  wire [7:0] pdo, got;
  integer failures = 0, total_checks = 0, i;
  reg [33:0] exp_q[$];
  initial forever #5 clk = ~clk;
  printer_port_status_control #(.GUARD_CYCLES(2)) i_printer_port_status_control (
    .clk_sys_in(clk), .resetn_in(rstn), .s_axi_awaddr_in(aw), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(ws),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(br), .s_axi_araddr_in(ar),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rdat),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rr),
    .pd_in(oe_n ? ext : pdo), .pd_out(pdo), .pd_oe_n_out(oe_n), .busy_in(busy),
    .ack_n_in(ackn), .paper_out_in(pe), .select_in(sl), .error_n_in(er),
    .strobe_n_out(stb_n), .init_n_out(ini_n), .select_in_n_out(sel_n),
    .auto_lf_n_out(alf_n), .irq_out(irq));
  printer_model i_printer_model (.clk_in(clk), .strobe_n_in(stb_n), .pd_in(pdo),
    .busy_out(busy), .ack_n_out(ackn), .got_out(got));
  task chk(input [33:0] s, input [33:0] e);
    begin
      total_checks = total_checks + 1;
      if (s !== e) begin
        failures = failures + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [4:0] a, input [31:0] v, input [1:0] r);
    begin
      exp_q.push_back({r, 32'h0});
      aw <= a;
      wd <= v;
      awv <= 1;
      wv <= 1;
      br <= 1;
      do begin
        @(posedge clk);
        if (awr) awv <= 0;
        if (wrd) wv <= 0;
      end while (!bv);
      br <= 0;
      @(posedge clk);
    end
  endtask
  task rd(input [4:0] a, input [33:0] e);
    begin
      exp_q.push_back(e);
      ar <= a;
      arv <= 1;
      rr <= 1;
      do begin
        @(posedge clk);
        if (arr) arv <= 0;
      end while (!rv);
      rr <= 0;
      @(posedge clk);
    end
  endtask
  always @(posedge clk) begin
    if (bv && br) chk({bresp, 32'h0}, exp_q.pop_front());
    if (rv && rr) chk({rresp, rdat}, exp_q.pop_front());
  end
  task final_report;
    begin
      if (failures == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  // The whole run needs a few hundred cycles; this cuts a hang short.
  initial begin
    #200000;
    failures = failures + 1;
    final_report;
  end
  initial begin
    x = $urandom(77497);
    repeat (16) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    rd(5'h08, 34'hc4);
    rd(5'h00, 34'h0);
    for (i = 0; i < 8; i = i + 1) begin
      x = $urandom;
      {pe, sl, er} <= x[10:8];
      ext <= x[23:16];
      c = x[7:0] & 8'h3e;
      wr(5'h08, {24'h0, c}, 2'h0);
      @(posedge clk);
      #1 chk({30'h0, oe_n, ini_n, sel_n, alf_n}, {30'h0, c[5], c[2], ~c[3], ~c[1]});
      rd(5'h08, {26'h0, 3'h6, c[4:0]});
      rd(5'h04, {26'h0, 2'h1, pe, sl, er, 3'h7});
      rd(5'h14, {26'h0, c[5] ? ext : d});
    end
    {pe, sl, er} <= 3'h3;
    d = x[31:24];
    wr(5'h10, 32'h1, 2'h0);
    wr(5'h00, {24'h0, d}, 2'h0);
    rd(5'h00, {26'h0, d});
    wr(5'h08, 32'h15, 2'h0);
    repeat (4) @(posedge clk);
    rd(5'h04, 34'hdf);
    wr(5'h00, {24'h0, ~d}, 2'h0);
    rd(5'h00, {26'h0, d});
    wr(5'h08, 32'h14, 2'h0);
    for (i = 0; i < 300 && irq !== 1'b1; i = i + 1) @(posedge clk);
    #1 chk({33'h0, irq}, 34'h1);
    chk({26'h0, got}, {26'h0, d});
    rd(5'h0c, 34'h3);
    wr(5'h0c, 32'h3, 2'h0);
    @(posedge clk);
    #1 chk({33'h0, irq}, 34'h0);
    wr(5'h08, 32'h05, 2'h0);
    repeat (4) @(posedge clk);
    wr(5'h08, 32'h04, 2'h0);
    repeat (100) @(posedge clk);
    rd(5'h0c, 34'h2);
    ws <= 4'h0;
    wr(5'h08, 32'h3e, 2'h0);
    ws <= 4'hf;
    rd(5'h08, 34'hc4);
    wr(5'h04, 32'h0, 2'h2);
    wr(5'h18, 32'h0, 2'h2);
    final_report;
  end
endmodule // printer_port_status_control_bench
